// >>> src/pwc_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pwc_edge_sync
   import pwc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic pin_i,
   input wire pwc_edge_t sel_i,
   output logic edge_o,
   output logic rise_o
);

   // ****************************************
   // two-flop synchroniser, then edge compare
   // ****************************************
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;
   logic rise;
   logic fall;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign rise = sync_reg & ~prev_reg;
   assign fall = ~sync_reg & prev_reg;
   assign rise_o = rise;
   assign edge_o = (sel_i == PWC_EDGE_RISE) ? rise :
                   (sel_i == PWC_EDGE_FALL) ? fall :
                   (sel_i == PWC_EDGE_BOTH) ? (rise | fall) : 1'b0;

endmodule : pwc_edge_sync
`default_nettype wire

// >>> src/pwc_pkg.sv
package pwc_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CTRL_ZERO = 8'h00;
   localparam logic [7:0] OFF_CTRL_ONE = 8'h04;
   localparam logic [7:0] OFF_OUT_CTL = 8'h08;
   localparam logic [7:0] OFF_EDGE_SEL = 8'h0C;
   localparam logic [7:0] OFF_EXT_IN_CTL = 8'h10;
   localparam logic [7:0] OFF_OPT_ZERO = 8'h14;
   localparam logic [7:0] OFF_CNT_BUF = 8'h18;
   localparam logic [7:0] OFF_CAP_ZERO = 8'h1C;
   localparam logic [7:0] OFF_CAP_ONE = 8'h20;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

   // ****************************************
   // fields and values
   // ****************************************
   localparam int unsigned CE_BIT = 7;
   localparam int unsigned EXT_CLK_BIT = 6;
   localparam int unsigned OVF_BIT = 0;
   localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
   localparam logic [15:0] CNT_CLEAR = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int unsigned IRQ_CAP0 = 0;
   localparam int unsigned IRQ_CAP1 = 1;
   localparam int unsigned IRQ_OVF = 2;
   localparam int unsigned IRQ_W = 3;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      PWC_EDGE_NONE,
      PWC_EDGE_RISE,
      PWC_EDGE_FALL,
      PWC_EDGE_BOTH
   } pwc_edge_t;

   typedef struct packed {
      pwc_edge_t pin1;
      pwc_edge_t pin0;
   } pwc_edge_cfg_t;

   typedef struct packed {
      logic level1;
      logic enable1;
      logic level0;
      logic enable0;
   } pwc_out_ctl_t;

endpackage : pwc_pkg

// >>> src/pwc_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
module pwc_tick_gen #(
   parameter int unsigned DIV_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic en_i,
   input wire logic [2:0] div_sel_i,
   input wire logic ext_sel_i,
   input wire logic ext_rise_i,
   output logic tick_o
);

   // ****************************************
   // count clock: power-of-two divider or pin
   // ****************************************
   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] div_mask;

   // divider restarts while the count is stopped, not on a capture, so the first tick is predictable
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         div_reg <= '0;
      end else if (!en_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   assign div_mask = ~({DIV_W{1'b1}} << div_sel_i);
   assign tick_o = en_i & (ext_sel_i ? ext_rise_i : ((div_reg & div_mask) == div_mask));

endmodule : pwc_tick_gen
`default_nettype wire

// >>> src/pwc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module pwc_timer
   import pwc_pkg::*;
#(
   parameter int unsigned DIV_W = 8
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic capture_input_zero_i,
   input wire logic capture_input_one_i,
   output logic [1:0] timer_output_pin_o,
   output logic [1:0] capture_irq_o,
   output logic overflow_irq_o,
   output logic irq_o
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == OFF_CTRL_ZERO) || (a == OFF_CTRL_ONE) || (a == OFF_OUT_CTL) ||
                  (a == OFF_EDGE_SEL) || (a == OFF_EXT_IN_CTL) || (a == OFF_OPT_ZERO) ||
                  (a == OFF_CNT_BUF) || (a == OFF_CAP_ZERO) || (a == OFF_CAP_ONE) ||
                  (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
   endfunction : is_mapped

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   // ****************************************
   // declarations
   // ****************************************
   logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
   logic awready_reg, wready_reg, bvalid_reg, bvalid_next;
   logic [1:0] bresp_reg;
   logic [7:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic arready_reg, rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rd_mux;
   logic [1:0] rresp_reg;
   logic aw_take, w_take, do_write, ar_take;
   logic wr_ctrl0, wr_ctrl1, wr_out, wr_edge, wr_ext, wr_opt, wr_cap0, wr_cap1;
   logic wr_stat, wr_mask;
   logic [7:0] ctrl0_reg, ctrl1_reg, ext_ctl_reg;
   pwc_out_ctl_t out_ctl_reg;
   pwc_edge_cfg_t edge_cfg_reg;
   logic [15:0] cnt_reg, cnt_next, cap0_reg, cap0_next, cap1_reg, cap1_next;
   logic ovf_flag_reg, ovf_flag_next, opt_clr;
   logic [IRQ_W-1:0] stat_reg, stat_next, stat_set, stat_clr, mask_reg;
   logic run, ext_sel, tick, started_reg;
   logic edge0, edge1, rise0, cap0_evt, cap1_evt, cap_any, ovf_evt;
   logic [1:0] pin_reg, pin_next, cap_irq_reg;
   logic ovf_irq_reg, irq_reg;

   // ****************************************
   // bus slave, write side
   // ****************************************
   assign aw_take = s_axi_awvalid_i & awready_reg;
   assign w_take = s_axi_wvalid_i & wready_reg;
   assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign aw_full_next = aw_take | (aw_full_reg & ~do_write);
   assign w_full_next = w_take | (w_full_reg & ~do_write);
   assign bvalid_next = do_write | (bvalid_reg & ~s_axi_bready_i);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         waddr_reg <= BYTE_ZERO;
         wdata_reg <= WORD_ZERO;
         wstrb_reg <= 4'h0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready_reg <= ~aw_full_next;
         wready_reg <= ~w_full_next;
         bvalid_reg <= bvalid_next;
         if (do_write) begin
            bresp_reg <= is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
         end
         if (aw_take) begin
            waddr_reg <= s_axi_awaddr_i;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
      end
   end

   assign wr_ctrl0 = do_write & (waddr_reg == OFF_CTRL_ZERO) & wstrb_reg[0];
   assign wr_ctrl1 = do_write & (waddr_reg == OFF_CTRL_ONE) & wstrb_reg[0];
   assign wr_out = do_write & (waddr_reg == OFF_OUT_CTL) & wstrb_reg[0];
   assign wr_edge = do_write & (waddr_reg == OFF_EDGE_SEL) & wstrb_reg[0];
   assign wr_ext = do_write & (waddr_reg == OFF_EXT_IN_CTL) & wstrb_reg[0];
   assign wr_opt = do_write & (waddr_reg == OFF_OPT_ZERO) & wstrb_reg[0];
   assign wr_cap0 = do_write & (waddr_reg == OFF_CAP_ZERO);
   assign wr_cap1 = do_write & (waddr_reg == OFF_CAP_ONE);
   assign wr_stat = do_write & (waddr_reg == OFF_IRQ_STAT) & wstrb_reg[0];
   assign wr_mask = do_write & (waddr_reg == OFF_IRQ_MASK) & wstrb_reg[0];

   // ****************************************
   // bus slave, read side
   // ****************************************
   assign ar_take = s_axi_arvalid_i & arready_reg;
   assign rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready_i);

   assign rd_mux = (s_axi_araddr_i == OFF_CTRL_ZERO) ? {24'h00_0000, ctrl0_reg} :
                   (s_axi_araddr_i == OFF_CTRL_ONE) ? {24'h00_0000, ctrl1_reg} :
                   (s_axi_araddr_i == OFF_OUT_CTL) ? {28'h000_0000, out_ctl_reg} :
                   (s_axi_araddr_i == OFF_EDGE_SEL) ? {28'h000_0000, edge_cfg_reg} :
                   (s_axi_araddr_i == OFF_EXT_IN_CTL) ? {24'h00_0000, ext_ctl_reg} :
                   (s_axi_araddr_i == OFF_OPT_ZERO) ? {31'h0000_0000, ovf_flag_reg} :
                   (s_axi_araddr_i == OFF_CNT_BUF) ? {16'h0000, cnt_reg} :
                   (s_axi_araddr_i == OFF_CAP_ZERO) ? {16'h0000, cap0_reg} :
                   (s_axi_araddr_i == OFF_CAP_ONE) ? {16'h0000, cap1_reg} :
                   (s_axi_araddr_i == OFF_IRQ_STAT) ? {29'h0000_0000, stat_reg} :
                   (s_axi_araddr_i == OFF_IRQ_MASK) ? {29'h0000_0000, mask_reg} :
                   WORD_ZERO;

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= WORD_ZERO;
         rresp_reg <= RESP_OKAY;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= rd_mux;
            rresp_reg <= is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   // ext control stored, never read by logic
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl0_reg <= BYTE_ZERO;
         ctrl1_reg <= BYTE_ZERO;
         out_ctl_reg <= '0;
         edge_cfg_reg <= '0;
         ext_ctl_reg <= BYTE_ZERO;
         mask_reg <= '0;
      end else begin
         if (wr_ctrl0) ctrl0_reg <= wdata_reg[7:0];
         if (wr_ctrl1) ctrl1_reg <= wdata_reg[7:0];
         if (wr_out) out_ctl_reg <= pwc_out_ctl_t'(wdata_reg[3:0]);
         if (wr_edge) edge_cfg_reg <= pwc_edge_cfg_t'(wdata_reg[3:0]);
         if (wr_ext) ext_ctl_reg <= wdata_reg[7:0];
         if (wr_mask) mask_reg <= wdata_reg[IRQ_W-1:0];
      end
   end

   // ****************************************
   // count clock and capture inputs
   // ****************************************
   // mode and enable gate the count
   assign run = ctrl0_reg[CE_BIT] & (ctrl1_reg[2:0] == MODE_PULSE_WIDTH);
   assign ext_sel = ctrl1_reg[EXT_CLK_BIT];

   pwc_edge_sync u_sync0 (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(capture_input_zero_i),
      .sel_i(edge_cfg_reg.pin0),
      .edge_o(edge0),
      .rise_o(rise0)
   );

   pwc_edge_sync u_sync1 (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .pin_i(capture_input_one_i),
      .sel_i(edge_cfg_reg.pin1),
      .edge_o(edge1),
      .rise_o()
   );

   pwc_tick_gen #(
      .DIV_W(DIV_W)
   ) u_tick (
      .ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i),
      .en_i(run),
      .div_sel_i(ctrl0_reg[2:0]),
      .ext_sel_i(ext_sel),
      .ext_rise_i(rise0),
      .tick_o(tick)
   );

   // input zero is the clock when ext_sel is set, and then never a trigger
   assign cap0_evt = run & edge0 & ~ext_sel;
   assign cap1_evt = run & edge1;
   assign cap_any = cap0_evt | cap1_evt;
   // overflow only when no capture clears first
   assign ovf_evt = run & tick & ~cap_any & (cnt_reg == CNT_MAX);

   // ****************************************
   // counter and capture registers
   // ****************************************
   // capture and clear take priority
   assign cnt_next = !run ? CNT_CLEAR :
                     cap_any ? CNT_CLEAR :
                     tick ? cnt_reg + 16'h0001 : cnt_reg;
   // capture beats a software write landing in the same cycle
   assign cap0_next = cap0_evt ? cnt_reg : wr_cap0 ? merge16(cap0_reg, wdata_reg, wstrb_reg) : cap0_reg;
   assign cap1_next = cap1_evt ? cnt_reg : wr_cap1 ? merge16(cap1_reg, wdata_reg, wstrb_reg) : cap1_reg;

   // write with bit0 clear drops the flag
   assign opt_clr = wr_opt & ~wdata_reg[OVF_BIT];
   assign ovf_flag_next = ovf_evt | (ovf_flag_reg & ~opt_clr);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_reg <= CNT_CLEAR;
         cap0_reg <= CNT_CLEAR;
         cap1_reg <= CNT_CLEAR;
         ovf_flag_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         cap0_reg <= cap0_next;
         cap1_reg <= cap1_next;
         ovf_flag_reg <= ovf_flag_next;
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   assign stat_set = {ovf_evt, cap1_evt, cap0_evt};
   assign stat_clr = wr_stat ? wdata_reg[IRQ_W-1:0] : '0;
   assign stat_next = stat_set | (stat_reg & ~stat_clr);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_reg <= '0;
         irq_reg <= 1'b0;
         cap_irq_reg <= 2'h0;
         ovf_irq_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         irq_reg <= |(stat_next & mask_reg);
         cap_irq_reg <= {cap1_evt, cap0_evt};
         ovf_irq_reg <= ovf_evt;
      end
   end

   // ****************************************
   // timer output pins
   // ****************************************
   // level, inverted while running when enabled; no toggling
   assign pin_next[0] = out_ctl_reg.level0 ^ (out_ctl_reg.enable0 & started_reg);
   assign pin_next[1] = out_ctl_reg.level1 ^ (out_ctl_reg.enable1 & started_reg);

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         started_reg <= 1'b0;
         pin_reg <= 2'h0;
      end else begin
         started_reg <= run;
         pin_reg <= pin_next;
      end
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign timer_output_pin_o = pin_reg;
   assign capture_irq_o = cap_irq_reg;
   assign overflow_irq_o = ovf_irq_reg;
   assign irq_o = irq_reg;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_count_runs: assert property (
      run && tick && !cap_any && cnt_reg != CNT_MAX |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("counter did not advance on tick");
   chk_count_idle: assert property (
      !run |=> cnt_reg == CNT_CLEAR)
      else $error("counter moved while stopped");
   chk_capture_copy: assert property (
      cap0_evt |=> cap0_reg == $past(cnt_reg) && cnt_reg == CNT_CLEAR && stat_reg[IRQ_CAP0]
                   && capture_irq_o[0])
      else $error("capture zero wrong");
   chk_capture_one: assert property (
      cap1_evt |=> cap1_reg == $past(cnt_reg) && capture_irq_o[1] ##1 !capture_irq_o[1] || cap1_evt)
      else $error("capture one wrong");
   chk_overflow_wrap: assert property (
      ovf_evt |=> cnt_reg == CNT_CLEAR && ovf_flag_reg && overflow_irq_o && stat_reg[IRQ_OVF])
      else $error("overflow not handled");
   chk_flag_clear: assert property (
      opt_clr && !ovf_evt |=> !ovf_flag_reg)
      else $error("overflow flag not cleared");
   chk_set_wins: assert property (
      opt_clr && ovf_evt |=> ovf_flag_reg)
      else $error("clear beat overflow set");
   chk_cnt_read: assert property (
      ar_take && s_axi_araddr_i == OFF_CNT_BUF
      |=> s_axi_rdata_o[15:0] == $past(cnt_reg) && ($stable(cap0_reg) || $past(cap_any)))
      else $error("counter read wrong");
   chk_edge_none: assert property (
      edge_cfg_reg.pin1 == PWC_EDGE_NONE |-> !cap1_evt)
      else $error("capture without edge select");
   chk_ext_clock: assert property (
      ext_sel |-> !cap0_evt)
      else $error("input zero captured as clock");
   chk_pin_level: assert property (
      !out_ctl_reg.enable0 |=> timer_output_pin_o[0] == $past(out_ctl_reg.level0))
      else $error("disabled pin not at level");
   chk_pin_running: assert property (
      started_reg && out_ctl_reg.enable1 |=> timer_output_pin_o[1] == !$past(out_ctl_reg.level1))
      else $error("running pin not inverted");

endmodule : pwc_timer
`default_nettype wire

// >>> test/pwc_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// pulse source on a capture pin
// ****************************************
module pwc_pulse_src (
   input wire logic ref_clk_i,
   input wire logic run_i,
   input wire logic [7:0] period_i,
   output logic pin_o
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   // high three clocks, so the sync stage never misses a level
   assign cnt_next = (cnt_reg == period_i - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
   always_ff @(posedge ref_clk_i) begin
      cnt_reg <= run_i ? cnt_next : 8'h00;
   end
   assign pin_o = run_i && (cnt_reg < 8'h03);
endmodule : pwc_pulse_src
`default_nettype wire

// >>> test/tb_pwc_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pwc_timer
   import pwc_pkg::*;
;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;
   localparam logic [33:0] RSP = 34'h3_0000_0000;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] strb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, run = 1'h0;
   logic [7:0] per = 8'h15;
   logic [31:0] d;
   logic [31:0] rdata;
   logic [1:0] pins, cirq, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, ovf, irq, cap0, cap1;
   logic [33:0] exp_q[$];
   logic [33:0] msk_q[$];
   int n_errors = 0, compares = 0, n_cap = 0, n_cap0 = 0, n_ovf = 0, cycles = 0;

   pwc_timer #(.DIV_W(8)) pwc_timer_i (.ref_clk_i(clk), .reset_n_i(rst_n),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .capture_input_zero_i(cap0),
      .capture_input_one_i(cap1), .timer_output_pin_o(pins), .capture_irq_o(cirq),
      .overflow_irq_o(ovf), .irq_o(irq));
   pwc_pulse_src pwc_pulse_src_i (.ref_clk_i(clk), .run_i(run), .period_i(per),
      .pin_o(cap1));
   // input zero pulses every five clocks: count clock or trigger, never both
   pwc_pulse_src pwc_pulse_src_clk_i (.ref_clk_i(clk), .run_i(run), .period_i(8'h05),
      .pin_o(cap0));

   initial begin
      forever #50 clk = ~clk;
   end

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         n_errors = n_errors + 1;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
      exp_q.push_back({r, 32'h0000_0000});
      msk_q.push_back(RSP);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      fork
         begin
            do @(posedge clk); while (!awready);
            awvalid <= 1'h0;
         end
         begin
            do @(posedge clk); while (!wready);
            wvalid <= 1'h0;
         end
      join
      do @(posedge clk); while (!bvalid);
      bready <= 1'h0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'h0;
      @(posedge clk);
   endtask : rd

   // ****************************************
   // monitor and timeout
   // ****************************************
   always @(posedge clk) begin
      cycles <= cycles + 1;
      n_cap <= n_cap + int'(cirq[1]);
      n_cap0 <= n_cap0 + int'(cirq[0]);
      n_ovf <= n_ovf + int'(ovf);
      if ((rvalid && rready) || (bvalid && bready)) begin
         chk((rvalid ? {rresp, rdata} : {bresp, 32'h0000_0000}) & msk_q[0], exp_q[0] & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (cycles == 90000) begin
         n_errors = n_errors + 1;
         final_report();
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      void'($urandom(20340));
      rd(OFF_CNT_BUF, 34'h0_0000_0000, ALL);
      rd(OFF_OPT_ZERO, 34'h0_0000_0000, ALL);
      rd(8'h3C, {RESP_SLVERR, WORD_ZERO}, ALL);
      wr(8'h3C, 32'h0000_0001, RESP_SLVERR);
      d = $urandom;
      wr(OFF_CAP_ONE, d, RESP_OKAY);
      rd(OFF_CAP_ONE, {RESP_OKAY, 16'h0000, d[15:0]}, ALL);
      $display("test registers done");
      // pin0 level 0, pin1 level 1, both enabled
      wr(OFF_OUT_CTL, 32'h0000_000D, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk({32'h0000_0000, pins}, 34'h0_0000_0002);
      wr(OFF_EDGE_SEL, 32'h0000_0004, RESP_OKAY);
      wr(OFF_EXT_IN_CTL, 32'h0000_00FF, RESP_OKAY);
      wr(OFF_IRQ_MASK, 32'h0000_0002, RESP_OKAY);
      wr(OFF_CTRL_ONE, {29'h0000_0000, MODE_PULSE_WIDTH}, RESP_OKAY);
      wr(OFF_CTRL_ZERO, 32'h0000_0080, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk({32'h0000_0000, pins}, 34'h0_0000_0001);
      $display("test start done");
      per <= 8'(2 * ($urandom % 8) + 21);
      run <= 1'h1;
      while (n_cap < 4) @(posedge clk);
      run <= 1'h0;
      rd(OFF_CAP_ONE, {RESP_OKAY, 24'h00_0000, per - 8'h01}, ALL);
      chk(34'(n_cap0), 34'h0_0000_0000);
      chk({33'h0_0000_0000, irq}, 34'h0_0000_0001);
      rd(OFF_IRQ_STAT, 34'h0_0000_0002, ALL);
      wr(OFF_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
      @(posedge clk);
      chk({33'h0_0000_0000, irq}, 34'h0_0000_0000);
      wr(OFF_IRQ_STAT, 32'h0000_0002, RESP_OKAY);
      rd(OFF_IRQ_STAT, 34'h0_0000_0000, ALL);
      chk({32'h0000_0000, pins}, 34'h0_0000_0001);
      $display("test capture done");
      while (n_ovf < 1) @(posedge clk);
      rd(OFF_CNT_BUF, 34'h0_0000_0000, 34'h3_FFFF_FF00);
      rd(OFF_OPT_ZERO, 34'h0_0000_0001, ALL);
      rd(OFF_IRQ_STAT, 34'h0_0000_0004, ALL);
      wr(OFF_OPT_ZERO, 32'h0000_00FE, RESP_OKAY);
      rd(OFF_OPT_ZERO, 34'h0_0000_0000, ALL);
      chk(34'(n_ovf), 34'h0_0000_0001);
      $display("test overflow done");
      wr(OFF_CTRL_ZERO, 32'h0000_0000, RESP_OKAY);
      repeat (3) @(posedge clk);
      chk({32'h0000_0000, pins}, 34'h0_0000_0002);
      $display("test stop done");
      per <= 8'h14;
      wr(OFF_CTRL_ONE, {25'h000_0000, 1'h1, 3'h0, MODE_PULSE_WIDTH}, RESP_OKAY);
      wr(OFF_CTRL_ZERO, 32'h0000_0080, RESP_OKAY);
      // four ticks per capture, the tick in the capture cycle is lost to the clear
      run <= 1'h1;
      while (n_cap < 8) @(posedge clk);
      run <= 1'h0;
      rd(OFF_CAP_ONE, {RESP_OKAY, 24'h00_0000, 8'h03}, ALL);
      $display("test external clock done");
      wr(OFF_CTRL_ONE, {29'h0000_0000, MODE_PULSE_WIDTH}, RESP_OKAY);
      wr(OFF_EDGE_SEL, 32'h0000_0001, RESP_OKAY);
      run <= 1'h1;
      while (n_cap0 < 3) @(posedge clk);
      run <= 1'h0;
      rd(OFF_CAP_ZERO, {RESP_OKAY, 24'h00_0000, 8'h04}, ALL);
      chk(34'(n_cap), 34'h0_0000_0008);
      $display("test input zero done");
      final_report();
   end
endmodule : tb_pwc_timer
`default_nettype wire
